// ### src/tcc_pkg.sv
// constants shared by the lower timer control block
package tcc_pkg;
  // ****************************************
  // register indexes and byte addresses
  // ****************************************
  localparam logic [11:0] CTL_IDX       = 12'h029;
  localparam logic [11:0] UPPER_CTL_IDX = 12'h02a;
  localparam logic [11:0] PERIOD_IDX    = 12'h030;
  localparam logic [11:0] PWIDTH_IDX    = 12'h031;
  localparam logic [11:0] STATUS_IDX    = 12'h032;
  localparam logic [11:0] ADDR_CTL       = CTL_IDX * 12'h004;
  localparam logic [11:0] ADDR_UPPER_CTL = UPPER_CTL_IDX * 12'h004;
  localparam logic [11:0] ADDR_PERIOD    = PERIOD_IDX * 12'h004;
  localparam logic [11:0] ADDR_PWIDTH    = PWIDTH_IDX * 12'h004;
  localparam logic [11:0] ADDR_STATUS    = STATUS_IDX * 12'h004;
  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int FF_BIT    = 7;
  localparam int CK_LSB    = 4;
  localparam int RUN_BIT   = 3;
  localparam int MODE_LSB  = 0;
  localparam logic [7:0] CTL_RESET    = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'hff;
  localparam logic [7:0] PWIDTH_RESET = 8'hff;
  // ****************************************
  // modes, clock codes, timing
  // ****************************************
  localparam logic [2:0] MODE_TIMER = 3'h0;
  localparam logic [2:0] MODE_DIVOUT = 3'h1;
  localparam logic [2:0] MODE_PWM   = 3'h2;
  localparam logic [2:0] MODE_CASC  = 3'h3;
  localparam logic [2:0] CK_SLOWEST = 3'h0;
  localparam logic [2:0] CK_FC7     = 3'h1;
  localparam logic [2:0] CK_FC5     = 3'h2;
  localparam logic [2:0] CK_FC3     = 3'h3;
  localparam logic [2:0] CK_FS      = 3'h4;
  localparam logic [2:0] CK_FC1     = 3'h5;
  localparam logic [2:0] CK_FC      = 3'h6;
  localparam logic [2:0] CK_PIN     = 3'h7;
  localparam int PRESCALE_W = 11;
  localparam logic [2:0] FS_DIV_MAX = 3'h7;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage

// ### src/tcc_src_sel.sv
// source clock tick selection and prescaler
`timescale 1ns/10ps
`default_nettype none
module tcc_src_sel (
  input  wire logic       hclk,
  input  wire logic       hresetn,
  input  wire logic       ce,
  input  wire logic [2:0] clk_select,
  input  wire logic       divider_stage_select,
  input  wire logic       low_power,
  input  wire logic       fs_tick,
  input  wire logic       ext_pin,
  output logic            src_tick
);
  logic [tcc_pkg::PRESCALE_W-1:0] pre_reg;
  logic [tcc_pkg::PRESCALE_W-1:0] pre_next;
  logic [2:0]                     fsc_reg;
  logic [2:0]                     fsc_next;
  logic                           pin_reg;
  logic                           tick_reg;
  logic                           tick_next;

  // true when the low n prescaler bits are all ones
  function automatic logic stage_done(input logic [tcc_pkg::PRESCALE_W-1:0] p, input int n);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < tcc_pkg::PRESCALE_W; i++) begin
      if (i < n && !p[i]) begin
        ok = 1'b0;
      end
    end
    return ok;
  endfunction

  // ****************************************
  // tick selection
  // ****************************************
  always_comb begin
    pre_next = pre_reg + 1'b1;
    fsc_next = fs_tick ? fsc_reg + 3'h1 : fsc_reg;
    case (clk_select)
      tcc_pkg::CK_SLOWEST: begin
        if (divider_stage_select || low_power) begin
          tick_next = fs_tick && (fsc_reg == tcc_pkg::FS_DIV_MAX);
        end else begin
          tick_next = stage_done(pre_reg, 11);
        end
      end
      tcc_pkg::CK_FC7: tick_next = stage_done(pre_reg, 7);
      tcc_pkg::CK_FC5: tick_next = stage_done(pre_reg, 5);
      tcc_pkg::CK_FC3: tick_next = stage_done(pre_reg, 3);
      tcc_pkg::CK_FS:  tick_next = fs_tick;
      tcc_pkg::CK_FC1: tick_next = pre_reg[0];
      tcc_pkg::CK_FC:  tick_next = 1'b1;
      tcc_pkg::CK_PIN: tick_next = ext_pin && !pin_reg; // rising pin edges
      default:         tick_next = 1'b0;
    endcase
  end

  // prescaler, fs divider and pin history
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_reg  <= '0;
      fsc_reg  <= 3'h0;
      pin_reg  <= 1'b0;
      tick_reg <= 1'b0;
    end else if (ce) begin
      pre_reg  <= pre_next;
      fsc_reg  <= fsc_next;
      pin_reg  <= ext_pin;
      tick_reg <= tick_next;
    end
  end

  assign src_tick = tick_reg;

  a_full_fc_tick: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && clk_select == tcc_pkg::CK_FC |=> src_tick)
    else $error("full clock code did not tick");
endmodule
`default_nettype wire

// ### src/tcc_timer5.sv
// lower timer control: registers on ahb-lite, counter, flip-flop, cascade
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
module tcc_timer5 (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        divider_stage_select,
  input  wire logic        slow_power_mode,
  input  wire logic        sleep_power_mode,
  input  wire logic        fs_tick,
  input  wire logic        ext_pin,
  output logic             timer_out,
  output logic             match_pulse,
  output logic             upper_tick
);
  logic [7:0]  ctl_reg;
  logic [7:0]  ctl_next;
  logic [7:0]  upper_ctl_reg;
  logic [7:0]  upper_ctl_next;
  logic [7:0]  period_reg;
  logic [7:0]  period_next;
  logic [7:0]  pwidth_reg;
  logic [7:0]  pwidth_next;
  logic        wr_reg;
  logic        wr_next;
  logic [11:0] waddr_reg;
  logic [11:0] waddr_next;
  logic [31:0] hrdata_reg;
  logic [31:0] hrdata_next;
  logic [7:0]  cnt_reg;
  logic [7:0]  cnt_next;
  logic        ff_reg;
  logic        ff_next;
  logic        run_q_reg;
  logic        match_reg;
  logic        match_next;
  logic        carry_reg;
  logic        carry_next;
  logic [2:0]  mode;
  logic        cascade;
  logic        eff_run;
  logic        preset;
  logic        src_tick;
  logic        addr_ok;

  // ****************************************
  // control decode
  // ****************************************
  assign mode    = ctl_reg[tcc_pkg::MODE_LSB +: 3];
  assign cascade = (mode == tcc_pkg::MODE_CASC);
  // cascade borrows run and preset from the upper control
  assign eff_run = cascade ? upper_ctl_reg[tcc_pkg::RUN_BIT] : ctl_reg[tcc_pkg::RUN_BIT];
  assign preset  = cascade ? upper_ctl_reg[tcc_pkg::FF_BIT] : ctl_reg[tcc_pkg::FF_BIT];

  // source selection always from this timer's clock field
  tcc_src_sel u_src (
    .hclk                 (hclk),
    .hresetn              (hresetn),
    .ce                   (ce),
    .clk_select           (ctl_reg[tcc_pkg::CK_LSB +: 3]),
    .divider_stage_select (divider_stage_select),
    .low_power            (slow_power_mode || sleep_power_mode),
    .fs_tick              (fs_tick),
    .ext_pin              (ext_pin),
    .src_tick             (src_tick)
  );

  // ****************************************
  // ahb-lite slave
  // ****************************************
  assign addr_ok = hsel && hready && htrans == tcc_pkg::HTRANS_NONSEQ;

  // address phase capture, read data and register writes
  always_comb begin
    wr_next        = addr_ok && hwrite;
    waddr_next     = haddr;
    hrdata_next    = 32'h0000_0000;
    ctl_next       = ctl_reg;
    upper_ctl_next = upper_ctl_reg;
    period_next    = period_reg;
    pwidth_next    = pwidth_reg;
    if (addr_ok && !hwrite) begin
      case (haddr)
        tcc_pkg::ADDR_CTL:       hrdata_next = {24'h000000, ctl_reg};
        tcc_pkg::ADDR_UPPER_CTL: hrdata_next = {24'h000000, upper_ctl_reg};
        tcc_pkg::ADDR_PERIOD:    hrdata_next = {24'h000000, period_reg};
        tcc_pkg::ADDR_PWIDTH:    hrdata_next = {24'h000000, pwidth_reg};
        tcc_pkg::ADDR_STATUS:    hrdata_next = {22'h000000, eff_run, ff_reg, cnt_reg};
        default:                 hrdata_next = 32'h0000_0000;
      endcase
    end
    if (wr_reg) begin
      case (waddr_reg)
        tcc_pkg::ADDR_CTL:       ctl_next = hwdata[7:0];
        tcc_pkg::ADDR_UPPER_CTL: upper_ctl_next = hwdata[7:0];
        tcc_pkg::ADDR_PERIOD:    period_next = hwdata[7:0];
        tcc_pkg::ADDR_PWIDTH:    pwidth_next = hwdata[7:0];
        default:                 ctl_next = ctl_reg;
      endcase
    end
  end

  // bus and register flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_reg        <= 1'b0;
      waddr_reg     <= 12'h000;
      hrdata_reg    <= 32'h0000_0000;
      ctl_reg       <= tcc_pkg::CTL_RESET;
      upper_ctl_reg <= tcc_pkg::CTL_RESET;
      period_reg    <= tcc_pkg::PERIOD_RESET;
      pwidth_reg    <= tcc_pkg::PWIDTH_RESET;
    end else if (ce) begin
      wr_reg        <= wr_next;
      waddr_reg     <= waddr_next;
      hrdata_reg    <= hrdata_next;
      ctl_reg       <= ctl_next;
      upper_ctl_reg <= upper_ctl_next;
      period_reg    <= period_next;
      pwidth_reg    <= pwidth_next;
    end
  end

  assign hreadyout = ce; // bus waits while frozen
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_reg;

  // ****************************************
  // counter and output flip-flop
  // ****************************************
  always_comb begin
    cnt_next   = cnt_reg;
    ff_next    = ff_reg;
    match_next = 1'b0;
    carry_next = 1'b0;
    if (!eff_run) begin
      cnt_next = 8'h00;
    end else if (!run_q_reg) begin
      cnt_next = 8'h00;
      ff_next  = preset;
    end else if (src_tick) begin
      case (mode)
        tcc_pkg::MODE_TIMER, tcc_pkg::MODE_DIVOUT: begin
          if (cnt_reg == period_reg) begin
            cnt_next   = 8'h00;
            match_next = 1'b1;
            ff_next    = (mode == tcc_pkg::MODE_DIVOUT) ? !ff_reg : ff_reg;
          end else begin
            cnt_next = cnt_reg + 8'h01;
          end
        end
        tcc_pkg::MODE_PWM: begin
          cnt_next = cnt_reg + 8'h01;
          if (cnt_reg == pwidth_reg) begin
            ff_next    = !ff_reg;
            match_next = 1'b1;
          end
          if (cnt_reg == 8'hff) begin
            ff_next = preset;
          end
        end
        tcc_pkg::MODE_CASC: begin
          cnt_next   = cnt_reg + 8'h01;
          carry_next = (cnt_reg == 8'hff);
        end
        default: cnt_next = cnt_reg;
      endcase
    end
  end

  // counter flops
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_reg   <= 8'h00;
      ff_reg    <= 1'b0;
      run_q_reg <= 1'b0;
      match_reg <= 1'b0;
      carry_reg <= 1'b0;
    end else if (ce) begin
      cnt_reg   <= cnt_next;
      ff_reg    <= ff_next;
      run_q_reg <= eff_run;
      match_reg <= match_next;
      carry_reg <= carry_next;
    end
  end

  assign timer_out   = ff_reg;
  assign match_pulse = match_reg;
  // upper byte clocks from lower overflow in its sixteen-bit modes
  assign upper_tick  = carry_reg && upper_ctl_reg[2];

  // ****************************************
  // checks
  // ****************************************
  a_stop_clears: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && !eff_run |=> cnt_reg == 8'h00)
    else $error("stopped counter not cleared");
  a_start_preset: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && eff_run && !run_q_reg |=> ff_reg == $past(preset))
    else $error("flip-flop not preset at start");
  a_ctl_reset: assert property (@(posedge hclk)
    $rose(hresetn) |-> ctl_reg == 8'h00)
    else $error("control not zero after reset");
  a_casc_upper_run: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && cascade && !upper_ctl_reg[tcc_pkg::RUN_BIT] |=> cnt_reg == 8'h00)
    else $error("cascade ran without upper run");
  a_upper_overflow: assert property (@(posedge hclk) disable iff (!hresetn)
    upper_tick |-> $past(cnt_reg) == 8'hff && $past(mode) == tcc_pkg::MODE_CASC)
    else $error("upper tick without lower overflow");
  a_timer_match: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && eff_run && run_q_reg && src_tick && mode == tcc_pkg::MODE_TIMER
    && cnt_reg == period_reg |=> cnt_reg == 8'h00 && match_pulse && $stable(ff_reg))
    else $error("timer match wrong");
  a_divout_toggle: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && eff_run && run_q_reg && src_tick && mode == tcc_pkg::MODE_DIVOUT
    && cnt_reg == period_reg |=> ff_reg != $past(ff_reg))
    else $error("divider output did not toggle");
  a_ctl_write: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && wr_reg && waddr_reg == tcc_pkg::ADDR_CTL |=> ctl_reg == $past(hwdata[7:0]))
    else $error("control write lost");
  a_casc_clock: assert property (@(posedge hclk) disable iff (!hresetn)
    ce && cascade && ctl_reg[tcc_pkg::CK_LSB +: 3] == tcc_pkg::CK_FC |=> src_tick)
    else $error("cascade ignores lower clock select");

  c_timer_match: cover property (@(posedge hclk) match_pulse && mode == tcc_pkg::MODE_TIMER);
  c_pwm_run: cover property (@(posedge hclk) eff_run && mode == tcc_pkg::MODE_PWM ##1 $changed(ff_reg));
  c_cascade: cover property (@(posedge hclk) upper_tick);
endmodule
`default_nettype wire

// ### verif/tcc_timer5_bench.sv
// self-checking bench for the lower timer control block
`timescale 1ns/10ps
`default_nettype none
module tcc_timer5_bench;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic        hclk        = 1'b0;
  logic        hresetn     = 1'b0;
  logic        ce          = 1'b1;
  logic        hsel        = 1'b1;
  logic [11:0] haddr       = 12'h000;
  logic [1:0]  htrans      = 2'h0;
  logic        hwrite      = 1'b0;
  logic [2:0]  hsize       = 3'h2;
  logic [31:0] hwdata      = 32'h0;
  logic        div_sel     = 1'b0;
  logic        slow_mode   = 1'b0;
  logic        sleep_mode  = 1'b0;
  logic        fs_tick     = 1'b0;
  logic        ext_pin     = 1'b0;
  wire logic   hready;
  logic        hresp;
  logic [31:0] hrdata;
  logic        timer_out;
  logic        match_pulse;
  logic        upper_tick;
  int          error_cnt   = 0;
  int          comparisons = 0;

  // clock at 40 mhz
  always #12.5 hclk = ~hclk;

  tcc_timer5 u_tcc_timer5 (
    .hclk                 (hclk),
    .hresetn              (hresetn),
    .ce                   (ce),
    .hsel                 (hsel),
    .haddr                (haddr),
    .htrans               (htrans),
    .hwrite               (hwrite),
    .hsize                (hsize),
    .hwdata               (hwdata),
    .hready               (hready),
    .hreadyout            (hready),
    .hresp                (hresp),
    .hrdata               (hrdata),
    .divider_stage_select (div_sel),
    .slow_power_mode      (slow_mode),
    .sleep_power_mode     (sleep_mode),
    .fs_tick              (fs_tick),
    .ext_pin              (ext_pin),
    .timer_out            (timer_out),
    .match_pulse          (match_pulse),
    .upper_tick           (upper_tick)
  );

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic finish_test;
    $display("errors %0d comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask

  // one single ahb-lite transfer, address phase then data phase
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge hclk);
    haddr  <= a;
    hwrite <= wr;
    htrans <= tcc_pkg::HTRANS_NONSEQ;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hready !== 1'b1);
    q = hrdata;
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    ahb(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp,
                        input logic [31:0] m);
    logic [31:0] q;
    ahb(1'b0, a, 32'h0, q);
    chk(name, exp, q & m);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask

  // cycles between two pulses of match (w=0) or upper tick (w=1)
  task automatic gap(input string name, input logic w, input int exp);
    int n;
    n = 0;
    while ((w ? upper_tick : match_pulse) !== 1'b1 && n < 2100) begin
      @(posedge hclk);
      n++;
    end
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while ((w ? upper_tick : match_pulse) !== 1'b1 && n < 2100);
    chk(name, 32'(exp), 32'(n));
  endtask

  // start with ctl, send n source edges, check count, stop keeping fields
  task automatic count_in(input logic [7:0] ctl, input logic pin, input int n,
                          input logic [31:0] exp);
    wr(tcc_pkg::ADDR_CTL, {24'h0, ctl});
    repeat (n) begin
      @(posedge hclk);
      if (pin) ext_pin <= 1'b1;
      else fs_tick <= 1'b1;
      @(posedge hclk);
      fs_tick <= 1'b0;
      @(posedge hclk);
      ext_pin <= 1'b0;
      repeat (2) @(posedge hclk);
    end
    rd_chk("count", tcc_pkg::ADDR_STATUS, exp, 32'h3ff);
    wr(tcc_pkg::ADDR_CTL, {24'h0, ctl & 8'hf7});
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset;
    rd_chk("ctl", tcc_pkg::ADDR_CTL, 32'h0, 32'hffffffff);
    rd_chk("upper", tcc_pkg::ADDR_UPPER_CTL, 32'h0, 32'hffffffff);
    rd_chk("period", tcc_pkg::ADDR_PERIOD, 32'hff, 32'hffffffff);
    rd_chk("pwidth", tcc_pkg::ADDR_PWIDTH, 32'hff, 32'hffffffff);
    rd_chk("status", tcc_pkg::ADDR_STATUS, 32'h0, 32'h3ff);
  endtask

  task automatic t_regs;
    wr(tcc_pkg::ADDR_CTL, 32'hf7);
    rd_chk("ctl_rw", tcc_pkg::ADDR_CTL, 32'hf7, 32'hffffffff);
    wr(tcc_pkg::ADDR_CTL, 32'h0);
    wr(12'h100, 32'hff);
    rd_chk("unmapped", 12'h100, 32'h0, 32'hffffffff);
    wr(tcc_pkg::ADDR_PWIDTH, 32'h5a);
    rd_chk("pwidth_rw", tcc_pkg::ADDR_PWIDTH, 32'h5a, 32'hffffffff);
  endtask

  task automatic t_timer;
    wr(tcc_pkg::ADDR_PERIOD, 32'h3);
    wr(tcc_pkg::ADDR_CTL, 32'h69);
    gap("divout_gap", 1'b0, 4);
    wr(tcc_pkg::ADDR_CTL, 32'h61);
    wr(tcc_pkg::ADDR_CTL, 32'h68);
    gap("timer_gap", 1'b0, 4);
    wr(tcc_pkg::ADDR_CTL, 32'h60);
    rd_chk("stop_clear", tcc_pkg::ADDR_STATUS, 32'h0, 32'h2ff);
    wr(tcc_pkg::ADDR_PERIOD, 32'hff);
  endtask

  task automatic t_preset;
    wr(tcc_pkg::ADDR_CTL, 32'he8);
    repeat (3) @(posedge hclk);
    chk("ff_set", 32'h1, {31'h0, timer_out});
    wr(tcc_pkg::ADDR_CTL, 32'he0);
    wr(tcc_pkg::ADDR_CTL, 32'h60);
    wr(tcc_pkg::ADDR_CTL, 32'h68);
    repeat (3) @(posedge hclk);
    chk("ff_clr", 32'h0, {31'h0, timer_out});
    wr(tcc_pkg::ADDR_CTL, 32'h60);
  endtask

  task automatic t_sources;
    count_in(8'h48, 1'b0, 5, 32'h205);
    sleep_mode <= 1'b1;
    count_in(8'h08, 1'b0, 16, 32'h202);
    sleep_mode <= 1'b0;
    slow_mode  <= 1'b1;
    count_in(8'h08, 1'b0, 16, 32'h202);
    slow_mode  <= 1'b0;
    div_sel    <= 1'b1;
    count_in(8'h08, 1'b0, 16, 32'h202);
    div_sel    <= 1'b0;
    count_in(8'h78, 1'b1, 5, 32'h205);
  endtask

  task automatic t_cascade;
    wr(tcc_pkg::ADDR_CTL, 32'h63);
    wr(tcc_pkg::ADDR_UPPER_CTL, 32'h0c);
    gap("casc_gap", 1'b1, 256);
    wr(tcc_pkg::ADDR_UPPER_CTL, 32'h04);
    wr(tcc_pkg::ADDR_CTL, 32'h6b);
    repeat (10) @(posedge hclk);
    rd_chk("casc_run", tcc_pkg::ADDR_STATUS, 32'h0, 32'h2ff);
    wr(tcc_pkg::ADDR_CTL, 32'h63);
    wr(tcc_pkg::ADDR_UPPER_CTL, 32'h8c);
    repeat (3) @(posedge hclk);
    chk("casc_ff", 32'h1, {31'h0, timer_out});
    wr(tcc_pkg::ADDR_UPPER_CTL, 32'h84);
    wr(tcc_pkg::ADDR_CTL, 32'h0);
    wr(tcc_pkg::ADDR_UPPER_CTL, 32'h0);
  endtask

  // a low clock enable holds the start and stretches the bus
  task automatic t_freeze;
    wr(tcc_pkg::ADDR_CTL, 32'h68);
    ce <= 1'b0;
    repeat (20) @(posedge hclk);
    chk("frozen_ready", 32'h0, {31'h0, hready});
    ce <= 1'b1;
    rd_chk("frozen_count", tcc_pkg::ADDR_STATUS, 32'h200, 32'h3ff);
    wr(tcc_pkg::ADDR_CTL, 32'h60);
  endtask

  // prescaled fc codes pace the matches, period one spans two ticks
  task automatic t_prescale;
    wr(tcc_pkg::ADDR_PERIOD, 32'h1);
    wr(tcc_pkg::ADDR_CTL, 32'h18);
    gap("fc7_gap", 1'b0, 256);
    wr(tcc_pkg::ADDR_CTL, 32'h10);
    wr(tcc_pkg::ADDR_CTL, 32'h28);
    gap("fc5_gap", 1'b0, 64);
    wr(tcc_pkg::ADDR_CTL, 32'h20);
    wr(tcc_pkg::ADDR_CTL, 32'h38);
    gap("fc3_gap", 1'b0, 16);
    wr(tcc_pkg::ADDR_CTL, 32'h30);
    wr(tcc_pkg::ADDR_CTL, 32'h58);
    gap("fc1_gap", 1'b0, 4);
    wr(tcc_pkg::ADDR_CTL, 32'h50);
    wr(tcc_pkg::ADDR_PERIOD, 32'h0);
    wr(tcc_pkg::ADDR_CTL, 32'h08);
    gap("fc11_gap", 1'b0, 2048);
    wr(tcc_pkg::ADDR_CTL, 32'h00);
    wr(tcc_pkg::ADDR_PERIOD, 32'hff);
  endtask

  // high time over one pwm period
  task automatic high_cnt(output int h);
    h = 0;
    repeat (256) begin
      @(posedge hclk);
      if (timer_out === 1'b1) h++;
    end
  endtask

  task automatic t_pwm;
    int h1;
    int h2;
    wr(tcc_pkg::ADDR_PWIDTH, 32'h10);
    wr(tcc_pkg::ADDR_CTL, 32'h6a);
    gap("pwm_gap", 1'b0, 256);
    high_cnt(h1);
    wr(tcc_pkg::ADDR_PWIDTH, 32'h20);
    gap("pwm_gap2", 1'b0, 256);
    high_cnt(h2);
    chk("pwm_width", 32'd16, 32'(h1 - h2));
    wr(tcc_pkg::ADDR_CTL, 32'h62);
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_regs;
    t_timer;
    t_preset;
    t_freeze;
    t_sources;
    t_prescale;
    t_cascade;
    t_pwm;
    finish_test;
  end

  // cuts a hang short well past the expected run length
  initial begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    finish_test;
  end
endmodule
`default_nettype wire
